// ---- shared/bmr_pkg.sv ----
// Shared constants and helpers for the banked mode register file
`default_nettype none
package bmr_pkg;
  localparam int XLEN     = 32;
  localparam int NUM_GPR  = 31;
  localparam int NUM_SAVE = 5;

  // Mode field encodings
  localparam logic [4:0] MODE_USER  = 5'h10;
  localparam logic [4:0] MODE_FAST  = 5'h11;
  localparam logic [4:0] MODE_IRQ   = 5'h12;
  localparam logic [4:0] MODE_SUPV  = 5'h13;
  localparam logic [4:0] MODE_ABORT = 5'h17;
  localparam logic [4:0] MODE_BAD_OPCODE_BANK = 5'h1B;
  localparam logic [4:0] MODE_SYS   = 5'h1F;

  // Status word field positions
  localparam int SW_N_BIT    = 31;
  localparam int SW_Z_BIT    = 30;
  localparam int SW_C_BIT    = 29;
  localparam int SW_V_BIT    = 28;
  localparam int SW_I_BIT    = 7;
  localparam int SW_F_BIT    = 6;
  localparam int SW_T_BIT    = 5;
  localparam int SW_MODE_LSB = 0;
  localparam logic [31:0] SW_RESET = 32'h000000D3;

  // Register indices with fixed roles
  localparam logic [3:0] IDX_FIRST_BANKED = 4'h8;
  localparam logic [3:0] IDX_STACK        = 4'hD;
  localparam logic [3:0] IDX_LINK         = 4'hE;
  localparam logic [3:0] IDX_PC           = 4'hF;

  // Physical slots: 0..15 user view, then private copies
  localparam logic [4:0] PH_PC         = 5'h0F;
  localparam logic [4:0] PH_FAST_BASE  = 5'h10;
  localparam logic [4:0] PH_IRQ_SP     = 5'h17;
  localparam logic [4:0] PH_SUPV_SP    = 5'h19;
  localparam logic [4:0] PH_ABORT_SP   = 5'h1B;
  localparam logic [4:0] PH_BAD_OPCODE_BANK_SP   = 5'h1D;

  // Exception request bit positions
  localparam int EXC_ABORT = 0;
  localparam int EXC_FAST  = 1;
  localparam int EXC_IRQ   = 2;
  localparam int EXC_BAD_OPCODE_BANK = 3;
  localparam int EXC_TRAP  = 4;

  // Entry addresses
  localparam logic [31:0] VEC_BAD_OPCODE_BANK = 32'h00000004;
  localparam logic [31:0] VEC_TRAP  = 32'h00000008;
  localparam logic [31:0] VEC_ABORT = 32'h00000010;
  localparam logic [31:0] VEC_IRQ   = 32'h00000018;
  localparam logic [31:0] VEC_FAST  = 32'h0000001C;

  // Saved status word slot of a mode; valid low for user and system
  function automatic logic [3:0] bmr_save_slot(input logic [4:0] mode);
    logic [3:0] r;
    r = 4'h0;
    case (mode)
      MODE_FAST:  r = 4'h8;
      MODE_IRQ:   r = 4'h9;
      MODE_SUPV:  r = 4'hA;
      MODE_ABORT: r = 4'hB;
      MODE_BAD_OPCODE_BANK: r = 4'hC;
      default:    r = 4'h0;
    endcase
    return r;
  endfunction
endpackage
`default_nettype wire

// ---- logic/bmr_bank_map.sv ----
// Logical register index to physical slot mapping per mode
`timescale 1ns/10ps
`default_nettype none
module bmr_bank_map
  import bmr_pkg::*;
(
  input  wire logic [4:0] mode,
  input  wire logic [3:0] idx,
  output logic      [4:0] phys
);
  logic [4:0] sp_base;
  logic       pair;

  assign pair = (idx == IDX_STACK) || (idx == IDX_LINK);

  always_comb
  begin
    sp_base = PH_SUPV_SP;
    case (mode)
      MODE_IRQ:   sp_base = PH_IRQ_SP;
      MODE_SUPV:  sp_base = PH_SUPV_SP;
      MODE_ABORT: sp_base = PH_ABORT_SP;
      MODE_BAD_OPCODE_BANK: sp_base = PH_BAD_OPCODE_BANK_SP;
      default:    sp_base = PH_SUPV_SP;
    endcase
  end

  always_comb
  begin
    // State bit is ignored, so both instruction widths share the low slots
    phys = {1'b0, idx};
    case (mode)
      MODE_FAST:
        if (idx >= IDX_FIRST_BANKED && idx != IDX_PC)
          phys = PH_FAST_BASE + {2'b00, idx[2:0]} - 5'h08 + {1'b0, idx[3], 3'b000};
      MODE_IRQ, MODE_SUPV, MODE_ABORT, MODE_BAD_OPCODE_BANK:
        if (pair)
          phys = sp_base + {4'h0, idx == IDX_LINK};
      // User, system and unknown encodings share the user view
      default:
        phys = {1'b0, idx};
    endcase
  end
endmodule
`default_nettype wire

// ---- logic/bmr_cond_check.sv ----
// Condition field evaluation against the arithmetic flags
`timescale 1ns/10ps
`default_nettype none
module bmr_cond_check
  import bmr_pkg::*;
(
  input  wire logic [3:0] cond,
  input  wire logic [3:0] nzcv,
  output logic            pass
);
  logic n, z, c, v;

  assign n = nzcv[3];
  assign z = nzcv[2];
  assign c = nzcv[1];
  assign v = nzcv[0];

  always_comb
  begin
    pass = 1'b0;
    case (cond)
      4'h0:    pass = z;
      4'h1:    pass = !z;
      4'h2:    pass = c;
      4'h3:    pass = !c;
      4'h4:    pass = n;
      4'h5:    pass = !n;
      4'h6:    pass = v;
      4'h7:    pass = !v;
      4'h8:    pass = c && !z;
      4'h9:    pass = !c || z;
      4'hA:    pass = n == v;
      4'hB:    pass = n != v;
      4'hC:    pass = !z && (n == v);
      4'hD:    pass = z || (n != v);
      4'hE:    pass = 1'b1;
      // Reserved code never executes
      default: pass = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ---- logic/bmr_regfile.sv ----
// Mode banked register file with status words and exception entry and return
//
// Contract
// - Seven modes: user, fast, irq, supervisor, abort, system, undefined; non-user privileged.
// - Thirty-one 32-bit general registers plus six status words in total.
// - Sixteen indices visible at once, chosen by mode; rest are shadows.
// - Index 15 is the program counter, readable by any instruction.
// - After a subroutine call index 14 holds the return address.
// - Indices 0 to 7 map to one shared physical register in every mode.
// - Indices 8 to 14 select physical registers that depend on mode.
// - Each exception mode owns private copies of indices 13 and 14.
// - Fast interrupt mode also owns private copies of indices 8 to 12.
// - System mode uses exactly the user registers while privileged.
// - Current status word holds negative, zero, carry and overflow flags.
// - Status word holds two interrupt disables, state bit, five-bit mode field.
// - Each exception mode owns a saved status word loaded on entry.
// - Exception entry loads the mode's private link register with return address.
// - Five exception types, each entering its own privileged mode.
// - Return copies saved word to current word and link to program counter.
// - Four-bit condition field in bits 31 to 28 decides execution.
// - Mode changes by software, interrupts or exceptions; mapping follows.
// - Several simultaneous exceptions resolve to a single entry.
// - Compact state low eight registers are the same physical registers.
`timescale 1ns/10ps
`default_nettype none
module bmr_regfile
  import bmr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [3:0]        rd_a_idx,
  output logic      [XLEN-1:0]   rd_a_data,
  input  wire logic [3:0]        rd_b_idx,
  output logic      [XLEN-1:0]   rd_b_data,
  input  wire logic              wr_en,
  input  wire logic [3:0]        wr_idx,
  input  wire logic [XLEN-1:0]   wr_data,
  input  wire logic              pc_wr_en,
  input  wire logic [XLEN-1:0]   pc_wr_data,
  output logic      [XLEN-1:0]   program_counter,
  input  wire logic              call_en,
  input  wire logic [XLEN-1:0]   call_ret_addr,
  input  wire logic              status_wr_en,
  input  wire logic [XLEN-1:0]   status_wr_data,
  input  wire logic              flags_wr_en,
  input  wire logic [3:0]        flags_in,
  output logic      [XLEN-1:0]   current_status_word,
  output logic                   privileged,
  input  wire logic              saved_wr_en,
  input  wire logic [XLEN-1:0]   saved_wr_data,
  output logic      [XLEN-1:0]   saved_status_word,
  input  wire logic [4:0]        exc_req,
  input  wire logic [XLEN-1:0]   exc_ret_addr,
  output logic                   exc_taken,
  input  wire logic              ret_en,
  input  wire logic [XLEN-1:0]   instr_word,
  output logic                   cond_pass
);
  logic [XLEN-1:0] gpr_reg [0:NUM_GPR-1];
  logic [XLEN-1:0] saved_reg [0:NUM_SAVE-1];
  logic [XLEN-1:0] status_reg;
  logic            exc_taken_reg;

  logic [4:0]      mode;
  logic [4:0]      ph_a, ph_b, ph_wr, ph_link, ph_exc_link;
  logic [3:0]      slot_cur, slot_exc;
  logic            save_valid;
  logic            exc_take;
  logic            ret_take;
  logic [4:0]      exc_mode;
  logic [XLEN-1:0] exc_vec;
  logic            mode_ok;
  logic [4:0]      wr_mode;

  assign mode = status_reg[SW_MODE_LSB +: 5];

  // Validity of a software-written mode field
  always_comb
  begin
    wr_mode = status_wr_data[SW_MODE_LSB +: 5];
    case (wr_mode)
      MODE_USER, MODE_FAST, MODE_IRQ, MODE_SUPV,
      MODE_ABORT, MODE_BAD_OPCODE_BANK, MODE_SYS: mode_ok = 1'b1;
      default:                          mode_ok = 1'b0;
    endcase
  end

  assign privileged = (mode != MODE_USER);

  // Port and link mappings use the live mode, so they follow every change; the entry link map uses exc_mode
  bmr_bank_map u_map_a
  (
    .mode (mode),
    .idx  (rd_a_idx),
    .phys (ph_a)
  );
  bmr_bank_map u_map_b
  (
    .mode (mode),
    .idx  (rd_b_idx),
    .phys (ph_b)
  );
  bmr_bank_map u_map_wr
  (
    .mode (mode),
    .idx  (wr_idx),
    .phys (ph_wr)
  );
  bmr_bank_map u_map_link
  (
    .mode (mode),
    .idx  (IDX_LINK),
    .phys (ph_link)
  );
  bmr_bank_map u_map_exc
  (
    .mode (exc_mode),
    .idx  (IDX_LINK),
    .phys (ph_exc_link)
  );

  bmr_cond_check u_cond
  (
    .cond (instr_word[31:28]),
    .nzcv (status_reg[SW_N_BIT:SW_V_BIT]),
    .pass (cond_pass)
  );

  // Interrupts are masked by their disable bits; others always enter
  always_comb
  begin
    exc_take = 1'b1;
    exc_mode = MODE_SUPV;
    exc_vec  = VEC_TRAP;
    if (exc_req[EXC_ABORT])
    begin
      exc_mode = MODE_ABORT;
      exc_vec  = VEC_ABORT;
    end
    else if (exc_req[EXC_FAST] && !status_reg[SW_F_BIT])
    begin
      exc_mode = MODE_FAST;
      exc_vec  = VEC_FAST;
    end
    else if (exc_req[EXC_IRQ] && !status_reg[SW_I_BIT])
    begin
      exc_mode = MODE_IRQ;
      exc_vec  = VEC_IRQ;
    end
    else if (exc_req[EXC_BAD_OPCODE_BANK])
    begin
      exc_mode = MODE_BAD_OPCODE_BANK;
      exc_vec  = VEC_BAD_OPCODE_BANK;
    end
    else if (exc_req[EXC_TRAP])
    begin
      exc_mode = MODE_SUPV;
      exc_vec  = VEC_TRAP;
    end
    else
    begin
      exc_take = 1'b0;
    end
  end

  assign slot_cur   = bmr_save_slot(mode);
  assign slot_exc   = bmr_save_slot(exc_mode);
  assign save_valid = slot_cur[3];
  // Return only from a mode that owns a saved word; entry wins over return
  assign ret_take   = ret_en && save_valid && !exc_take;

  // General registers: later assignments take priority
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < NUM_GPR; i++)
        gpr_reg[i] <= '0;
    end
    else
    begin
      if (pc_wr_en)
        gpr_reg[PH_PC] <= pc_wr_data;
      if (wr_en && !exc_take)
        gpr_reg[ph_wr] <= wr_data;
      if (call_en && !exc_take)
        gpr_reg[ph_link] <= call_ret_addr;
      if (ret_take)
        gpr_reg[PH_PC] <= gpr_reg[ph_link];
      if (exc_take)
      begin
        gpr_reg[ph_exc_link] <= exc_ret_addr;
        gpr_reg[PH_PC]       <= exc_vec;
      end
    end
  end

  // Current status word
  always_ff @(posedge clk)
  begin
    if (reset)
      status_reg <= SW_RESET;
    else if (exc_take)
    begin
      status_reg[SW_MODE_LSB +: 5] <= exc_mode;
      status_reg[SW_T_BIT]         <= 1'b0;
      status_reg[SW_I_BIT]         <= 1'b1;
      if (exc_mode == MODE_FAST)
        status_reg[SW_F_BIT] <= 1'b1;
    end
    else if (ret_take)
      status_reg <= saved_reg[slot_cur[2:0]];
    else if (status_wr_en && privileged)
    begin
      status_reg[31:5] <= status_wr_data[31:5];
      // Unknown encodings would leave no legal bank, so keep the old mode
      if (mode_ok)
        status_reg[SW_MODE_LSB +: 5] <= wr_mode;
    end
    else if (status_wr_en)
      status_reg[SW_N_BIT:SW_V_BIT] <= status_wr_data[SW_N_BIT:SW_V_BIT];
    else if (flags_wr_en)
      status_reg[SW_N_BIT:SW_V_BIT] <= flags_in;
  end

  // Saved status words
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < NUM_SAVE; i++)
        saved_reg[i] <= '0;
    end
    else if (exc_take)
      saved_reg[slot_exc[2:0]] <= status_reg;
    else if (saved_wr_en && save_valid)
      saved_reg[slot_cur[2:0]] <= saved_wr_data;
  end

  // Registered read ports; a same-cycle write is not forwarded
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_a_data <= '0;
      rd_b_data <= '0;
    end
    else
    begin
      rd_a_data <= gpr_reg[ph_a];
      rd_b_data <= gpr_reg[ph_b];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      saved_status_word <= '0;
    else
      saved_status_word <= save_valid ? saved_reg[slot_cur[2:0]] : '0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      exc_taken_reg <= 1'b0;
    else
      exc_taken_reg <= exc_take;
  end

  assign exc_taken           = exc_taken_reg;
  assign program_counter     = gpr_reg[PH_PC];
  assign current_status_word = status_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_entry;
    exc_take;
  endsequence

  sequence s_saved_state;
    (gpr_reg[ph_link] == $past(exc_ret_addr)) && (saved_reg[slot_cur[2:0]] == $past(status_reg));
  endsequence

  property p_entry_saves;
    s_entry |=> s_saved_state;
  endproperty

  a_entry_state_saved: assert property (p_entry_saves)
    else $error("exception entry did not save link and status word");

  a_low_unbanked: assert property (rd_a_idx < IDX_FIRST_BANKED |-> ph_a == {1'b0, rd_a_idx})
    else $error("low register index mapped to a banked slot");

  a_fast_private: assert property ((mode == MODE_FAST) && (rd_b_idx >= IDX_FIRST_BANKED)
      && (rd_b_idx != IDX_PC) |-> ph_b >= PH_FAST_BASE && ph_b < PH_IRQ_SP)
    else $error("fast mode did not select its private copies");

  a_system_shared: assert property ((mode == MODE_SYS) |-> ph_a == {1'b0, rd_a_idx}
      && privileged)
    else $error("system mode did not use the user registers");

  a_fast_masks: assert property (exc_take && exc_mode == MODE_FAST
      |=> status_reg[SW_F_BIT] && status_reg[SW_I_BIT] && mode == MODE_FAST && exc_taken)
    else $error("fast entry did not set both disables");

  a_return_restore: assert property (ret_take |=>
      status_reg == $past(saved_reg[slot_cur[2:0]]) && program_counter == $past(gpr_reg[ph_link]))
    else $error("return did not restore status word and program counter");

  a_user_no_saved: assert property (!save_valid && !exc_take && !ret_take
      && !status_wr_en |=> saved_status_word == '0)
    else $error("saved status word visible in user or system mode");

  a_pc_readable: assert property (rd_a_idx == IDX_PC |=> rd_a_data == $past(program_counter))
    else $error("index 15 did not read the program counter");

  a_call_link: assert property (call_en && !exc_take && !ret_take && !status_wr_en
      |=> gpr_reg[ph_link] == $past(call_ret_addr))
    else $error("call did not load the link register");

  a_entry_vector: assert property (exc_req[EXC_ABORT] |=> mode == MODE_ABORT
      && program_counter == VEC_ABORT)
    else $error("abort did not win exception selection");

  a_cond_always: assert property (instr_word[31:28] == 4'hE |-> cond_pass)
    else $error("always condition did not pass");

  a_trap_supervisor: assert property (exc_take && exc_mode == MODE_SUPV
      |=> mode == MODE_SUPV && program_counter == VEC_TRAP && !status_reg[SW_T_BIT])
    else $error("software trap did not enter supervisor mode");

  a_irq_masked: assert property (status_reg[SW_I_BIT] && exc_req == 5'(1 << EXC_IRQ)
      |=> !exc_taken)
    else $error("masked interrupt was entered");

  a_flags_update: assert property (flags_wr_en && !exc_take && !ret_take && !status_wr_en
      |=> status_reg[SW_N_BIT:SW_V_BIT] == $past(flags_in))
    else $error("flag update did not reach the status word");
endmodule
`default_nettype wire

// ---- bench/bmr_irq_src.sv ----
// Interrupt source model standing in for the pipeline's interrupt lines
`timescale 1ns/10ps
`default_nettype none
module bmr_irq_src
  import bmr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       raise_fast,
  input  wire logic       raise_irq,
  input  wire logic [4:0] mode,
  output logic      [1:0] lines
);
  // Level held until the handler mode shows; a masked request must not be lost
  always_ff @(posedge clk)
  begin
    if (reset)
      lines <= 2'h0;
    else
    begin
      lines[0] <= (mode == MODE_FAST) ? 1'b0 : (lines[0] | raise_fast);
      lines[1] <= (mode == MODE_IRQ) ? 1'b0 : (lines[1] | raise_irq);
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb_banked_mode_register_file.sv ----
// Self-checking bench for the banked mode register file
`timescale 1ns/10ps
`default_nettype none
module tb_banked_mode_register_file
  import bmr_pkg::*;
;
  logic        clk, reset, wr_en, pc_wr_en, call_en, status_wr_en, flags_wr_en, saved_wr_en, ret_en;
  logic        exc_taken, privileged, cond_pass, raise_fast, raise_irq;
  logic [1:0]  src_lines;
  logic [3:0]  rd_a_idx, rd_b_idx, wr_idx, flags_in;
  logic [4:0]  exc_bits, exc_req;
  logic [31:0] rd_a_data, rd_b_data, wr_data, pc_wr_data, program_counter, call_ret_addr, instr_word;
  logic [31:0] status_wr_data, current_status_word, saved_wr_data, saved_status_word, exc_ret_addr;
  logic [4:0]  modes [7];
  int          n_errors, cmp_count;

  assign exc_req = {exc_bits[4:3], src_lines[1], src_lines[0], exc_bits[0]};

  bmr_regfile uut (.clk, .reset, .rd_a_idx, .rd_a_data, .rd_b_idx, .rd_b_data, .wr_en, .wr_idx, .wr_data,
    .pc_wr_en, .pc_wr_data, .program_counter, .call_en, .call_ret_addr, .status_wr_en, .status_wr_data,
    .flags_wr_en, .flags_in, .current_status_word, .privileged, .saved_wr_en, .saved_wr_data,
    .saved_status_word, .exc_req, .exc_ret_addr, .exc_taken, .ret_en, .instr_word, .cond_pass);
  bmr_irq_src src (.clk, .reset, .raise_fast, .raise_irq, .mode(current_status_word[4:0]), .lines(src_lines));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc;
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    wr_en = 1'b1;
    wr_idx = i;
    wr_data = d;
    cyc;
  endtask
  task automatic rdc(input logic [3:0] i, input logic [31:0] e);
    rd_a_idx = i;
    rd_b_idx = i;
    cyc;
    chk(rd_a_data, e);
    chk(rd_b_data, e);
  endtask
  task automatic stw(input logic [31:0] d);
    status_wr_en = 1'b1;
    status_wr_data = d;
    cyc;
    status_wr_en = 1'b0;
  endtask
  task automatic cnd(input logic [3:0] c, input logic e);
    instr_word = {c, 28'h0};
    cyc;
    chk({31'h0, cond_pass}, {31'h0, e});
  endtask
  function automatic logic [31:0] val(input logic [4:0] m, input logic [3:0] i);
    return {8'hC0, 11'h000, m, 4'h0, i};
  endfunction
  // Mode whose copy a read in mode m sees; system stands for the user view
  function automatic logic [4:0] bank(input logic [4:0] m, input logic [3:0] i);
    if (i < 4'h8 || (m != MODE_FAST && (i < 4'hD || m == MODE_USER)))
      return MODE_SYS;
    return m;
  endfunction

  task automatic t_banks;
    for (int k = 0; k < 6; k++)
    begin
      stw({24'h000000, 3'h6, modes[k]});
      for (int i = 0; i < 15; i++)
        wr(4'(i), val(modes[k], 4'(i)));
      // Strobe stays up across the burst and drops once
      wr_en = 1'b0;
    end
    // User last: it cannot switch back by a status write
    for (int k = 0; k < 7; k++)
    begin
      // Compact state set while reading back; mapping must ignore it
      stw({24'h000000, 3'h7, modes[k]});
      chk({27'h0, current_status_word[4:0]}, {27'h0, modes[k]});
      chk({31'h0, privileged}, {31'h0, k != 6});
      for (int i = 0; i < 15; i++)
        rdc(4'(i), val(bank(modes[k], 4'(i)), 4'(i)));
    end
    $display("test banks done");
  endtask

  task automatic t_user;
    stw(32'h5000001F);
    chk(current_status_word, 32'h500000F0);
    chk(saved_status_word, 32'h0);
    exc_bits = 5'h08;
    exc_ret_addr = 32'h40;
    cyc;
    exc_bits = 5'h00;
    chk(current_status_word, 32'h500000DB);
    chk(program_counter, VEC_BAD_OPCODE_BANK);
    chk({31'h0, exc_taken}, 32'h1);
    rdc(IDX_LINK, 32'h40);
    chk(saved_status_word, 32'h500000F0);
    stw(32'hF000001F);
    chk(current_status_word, 32'hF000001F);
    saved_wr_en = 1'b1;
    saved_wr_data = 32'h12345678;
    cyc;
    saved_wr_en = 1'b0;
    cyc;
    chk(saved_status_word, 32'h0);
    stw(32'hF0000005);
    chk(current_status_word, 32'hF000001F);
    pc_wr_en = 1'b1;
    pc_wr_data = 32'h1000;
    cyc;
    pc_wr_en = 1'b0;
    rdc(IDX_PC, 32'h1000);
    call_en = 1'b1;
    call_ret_addr = 32'h3000;
    cyc;
    call_en = 1'b0;
    rdc(IDX_LINK, 32'h3000);
    $display("test user done");
  endtask

  task automatic t_chain;
    exc_bits = 5'h01;
    raise_fast = 1'b1;
    raise_irq = 1'b1;
    exc_ret_addr = 32'h100;
    cyc;
    exc_bits = 5'h00;
    raise_fast = 1'b0;
    raise_irq = 1'b0;
    exc_ret_addr = 32'h200;
    chk(current_status_word, 32'hF0000097);
    chk(program_counter, VEC_ABORT);
    cyc;
    chk(current_status_word, 32'hF00000D1);
    chk(program_counter, VEC_FAST);
    ret_en = 1'b1;
    exc_ret_addr = 32'h300;
    cyc;
    chk(current_status_word, 32'hF0000097);
    chk(program_counter, 32'h200);
    cyc;
    ret_en = 1'b0;
    chk(program_counter, 32'h100);
    cyc;
    chk(current_status_word, 32'hF0000092);
    chk(program_counter, VEC_IRQ);
    rdc(IDX_LINK, 32'h300);
    chk(saved_status_word, 32'hF000001F);
    saved_wr_en = 1'b1;
    saved_wr_data = 32'h7000001F;
    cyc;
    saved_wr_en = 1'b0;
    cyc;
    chk(saved_status_word, 32'h7000001F);
    ret_en = 1'b1;
    cyc;
    ret_en = 1'b0;
    cyc;
    chk(current_status_word, 32'h7000001F);
    chk(program_counter, 32'h300);
    exc_bits = 5'h18;
    cyc;
    exc_bits = 5'h10;
    chk(program_counter, VEC_BAD_OPCODE_BANK);
    cyc;
    exc_bits = 5'h00;
    chk(current_status_word, 32'h70000093);
    chk(program_counter, VEC_TRAP);
    $display("test chain done");
  endtask

  task automatic t_cond;
    cnd(4'h0, 1'b1);
    cnd(4'h1, 1'b0);
    cnd(4'hE, 1'b1);
    flags_wr_en = 1'b1;
    flags_in = 4'h9;
    cyc;
    flags_wr_en = 1'b0;
    chk({28'h0, current_status_word[31:28]}, 32'h9);
    cnd(4'h0, 1'b0);
    cnd(4'h1, 1'b1);
    cnd(4'hA, 1'b1);
    cnd(4'hF, 1'b0);
    $display("test cond done");
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test;
  end

  initial
  begin
    modes = '{MODE_FAST, MODE_IRQ, MODE_SUPV, MODE_ABORT, MODE_BAD_OPCODE_BANK, MODE_SYS, MODE_USER};
    {reset, wr_en, pc_wr_en, call_en, status_wr_en, flags_wr_en, saved_wr_en, ret_en} = 8'h80;
    {raise_fast, raise_irq, exc_bits, rd_a_idx, rd_b_idx, wr_idx, flags_in} = 23'h0;
    {wr_data, pc_wr_data, call_ret_addr, instr_word} = 128'h0;
    {status_wr_data, saved_wr_data, exc_ret_addr} = 96'h0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    chk(current_status_word, SW_RESET);
    chk(program_counter, 32'h0);
    chk({31'h0, privileged}, 32'h1);
    t_banks;
    t_user;
    t_chain;
    t_cond;
    stop_test;
  end
endmodule
`default_nettype wire
